// File: sist_regs.svh
// Register indices, field positions, reset values and codes of the interrupt status block.
`ifndef SIST_REGS_SVH
`define SIST_REGS_SVH

// ====================
// Register indices; the byte address on the bus is four times the index
`define SIST_IDX_INT_STATUS 8'h21
`define SIST_IDX_CHIP_TEST 8'h22
`define SIST_IDX_PARITY 8'h23

// ====================
// Interrupt status and control fields
`define SIST_BIT_ABORT 7
`define SIST_BIT_SOFT_RESET 6
`define SIST_BIT_SIGNAL 5
`define SIST_BIT_CONNECTED 3
`define SIST_BIT_SCSI_PEND 1
`define SIST_BIT_DMA_PEND 0

// ====================
// Chip test fields
`define SIST_BIT_REV_HI 7
`define SIST_BIT_REV_LO 4
`define SIST_BIT_FLUSH 3
`define SIST_BIT_CLEAR_FIFOS 2
`define SIST_BIT_FETCH_MODE 1
`define SIST_BIT_SNOOP_MODE 0

// ====================
// Event positions and widths
`define SIST_SCSI_EVENTS 8
`define SIST_DMA_EVENTS 6
`define SIST_DMA_EV_BUS_FAULT 0
`define SIST_DMA_EV_ABORT 1
`define SIST_DMA_EV_WATCHDOG 4

// ====================
// Reset values and bus codes
`define SIST_RST_INT_STATUS 8'h00
`define SIST_RST_CHIP_TEST_LOW 4'h0
`define SIST_RST_PARITY 8'h00
`define SIST_RESP_OKAY 2'h0
`define SIST_RESP_SLVERR 2'h2
`define SIST_ADDR_W 10

`endif

// File: sist_pkg.sv
// Types shared by the interrupt status block.
package sist_pkg;

   // ====================
   // Halt sequencing
   typedef enum logic [1:0] {HALT_RUN, HALT_WAIT, HALT_DONE} sist_halt_e;

   // ====================
   // State of the top module, apart from the status latches held in sist_stack
   typedef struct packed {
      logic abortBit;
      logic softReset;
      logic signalFlag;
      logic connected;
      logic flushBit;
      logic clearBit;
      logic fetchModeBit;
      logic snoopModeBit;
      logic [7:0] parity;
      sist_halt_e halt;
      logic [2:0] hiZSync;
      logic hiZ;
      logic awPend;
      logic [9:0] awAddr;
      logic wPend;
      logic [7:0] wData;
      logic wStrb0;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [7:0] rData;
      logic [1:0] rResp;
   } sist_state_s;

endpackage

// File: sist_stack_if.sv
// Connection between the controller and one status latch with its pending stage.
`timescale 1ns/1ps
interface sist_stack_if #(parameter int W = 8);
   logic [W-1:0] evt;
   logic freeze;
   logic clear;
   logic wipe;
   logic [W-1:0] status;
   logic pending;

   modport ctrl (output evt, output freeze, output clear, output wipe,
                 input status, input pending);
   modport stack (input evt, input freeze, input clear, input wipe,
                  output status, output pending);
endinterface

// File: sist_stack.sv
// One status latch with a pending stage stacked behind it.
`timescale 1ns/1ps
module sist_stack
   import sist_pkg::*;
#(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Controller side
   sist_stack_if.stack port
);

   typedef struct packed {
      logic [W-1:0] status;
      logic [W-1:0] stacked;
   } sist_latch_s;

   sist_latch_s st;
   sist_latch_s next_st;

   // ====================
   // Latch and stack
   always_comb begin
      next_st = st;
      if (port.wipe) begin
         next_st = '0;
      end else if (port.clear) begin
         // An event arriving with the clear lands in the fresh status, not lost.
         next_st.status = st.stacked | port.evt; // [R2]
         next_st.stacked = '0;
      end else if (port.freeze) begin
         next_st.stacked = st.stacked | port.evt; // [R1]
      end else begin
         next_st.status = st.status | port.evt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign port.status = st.status;
   assign port.pending = |st.status;

endmodule

// File: sist_ctrl.sv
// Interrupt status, chip test and longitudinal parity registers behind AXI4-Lite.
`timescale 1ns/1ps
`include "sist_regs.svh"

// Summary of operation
// R1: While a pending flag is set, status latches freeze and new events stack.
// R2: Clearing a status by reading it moves stacked events in and re-interrupts.
// R3: Halt orderly before interrupting; finish a fetch unless bus fault or watchdog.
// R4: Drain FIFO on DMA writes, else finish current cycle or burst, then halt.
// R5: A begun transfer-control runs out; a phase wait aborts and loads its target.
// R6: Writing one to the abort bit aborts the operation with a DMA abort event.
// R7: Host aborts: set bit, wait, read status; clear with 00h before DMA status.
// R8: Soft reset bit holds all registers at default and releases SCSI signals; a status write still loads the abort and signal bits.
// R9: Soft reset bit stays set until written to zero or hardware reset.
// R10: Signal flag is host writable, poll-clearable, and branches selection waits.
// R11: Signal flag set at selection disables automatic role switching.
// R12: Connected flag sets on arbitration win or selection response; zero off bus.
// R13: SCSI pending sets on any of the eight SCSI interrupt conditions.
// R14: DMA pending sets on any of the six DMA interrupt conditions.
// R15: Chip test upper nibble returns a fixed revision code, also at reset.
// R16: Flush bit drains DMA FIFO to memory; host clears it afterwards.
// R17: Clear-FIFOs bit resets FIFO pointers and latch full flags, then self-clears.
// R18: Fetch mode set limits fetch indicator to opcode phase; clear covers all fetches.
// R19: Snoop mode set drives both pins always except high-impedance test mode.
// R20: Snoop mode clear drives both pins from snoop bits only during bus ownership.
// R21: Parity accumulates XOR of FIFO-core bytes; any host write clears it.
// R22: During selection the parity register loads the SCSI identifier.
module sist_ctrl
   import sist_pkg::*;
#(
   // Revision code; the value is arbitrary.
   parameter logic [3:0] REVISION = 4'h5
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // AXI4-Lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [`SIST_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // AXI4-Lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [`SIST_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // AXI4-Lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Interrupt events and status register reads
   input wire logic [`SIST_SCSI_EVENTS-1:0] scsiEvent,
   input wire logic [`SIST_DMA_EVENTS-1:0] dmaEvent,
   input wire logic scsiStatusRead,
   input wire logic dmaStatusRead,
   output logic [`SIST_SCSI_EVENTS-1:0] scsiCause,
   output logic [`SIST_DMA_EVENTS-1:0] dmaCause,
   output logic irq,
   // Halt handshake with the sequencer
   output logic haltRequest,
   input wire logic haltAck,
   output logic haltSkipFetch,
   input wire logic dmaWriteActive,
   output logic haltDrainFifo,
   output logic haltCurrentCycleOnly,
   input wire logic phaseWaitActive,
   output logic haltAbortPhaseWait,
   output logic abortRequest,
   // Soft reset
   output logic softResetActive,
   output logic scsiSignalsRelease,
   // Signal flag
   input wire logic signalPollClear,
   output logic selWaitBranch,
   output logic autoRoleSwitchEn,
   // Connection
   input wire logic arbitrationWon,
   input wire logic selectionResponded,
   input wire logic onScsiBus,
   // FIFO control
   output logic flushFifo,
   output logic clearFifos,
   input wire logic clearFifosDone,
   // Fetch indicator
   input wire logic fetchCycle,
   input wire logic fetchOpcodePhase,
   output logic fetchIndicator,
   // Snoop pins
   input wire logic internalBusReq,
   input wire logic hostBusOwned,
   input wire logic [1:0] snoopCtlBits,
   input wire logic hiZTestPin,
   output logic snoopPinZero,
   output logic snoopPinZeroOe,
   output logic snoopPinOne,
   output logic snoopPinOneOe,
   // Parity stream and identifier load
   input wire logic [7:0] parityByte,
   input wire logic parityByteValid,
   input wire logic idLoad,
   input wire logic [7:0] idValue
);

   localparam sist_state_s ST_RESET = '{halt: HALT_RUN, default: '0};

   sist_state_s st;
   sist_state_s next_st;

   sist_stack_if #(.W(`SIST_SCSI_EVENTS)) scsiIf ();
   sist_stack_if #(.W(`SIST_DMA_EVENTS)) dmaIf ();

   logic scsiPend;
   logic dmaPend;
   logic [7:0] intStatusRead;
   logic [7:0] chipTestRead;
   logic commitWrite;
   logic [7:0] wIdx;
   logic [7:0] rIdx;
   logic wLane;

   // ====================
   // Status latches with pending stages
   sist_stack #(.W(`SIST_SCSI_EVENTS)) scsiStack (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .port(scsiIf.stack)
   );

   sist_stack #(.W(`SIST_DMA_EVENTS)) dmaStack (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .port(dmaIf.stack)
   );

   assign scsiPend = scsiIf.pending; // [R13]
   assign dmaPend = dmaIf.pending; // [R14]

   // Both latches close together while either source has an interrupt up.
   assign scsiIf.freeze = scsiPend | dmaPend; // [R1]
   assign dmaIf.freeze = scsiPend | dmaPend; // [R1]
   assign scsiIf.clear = scsiStatusRead; // [R2]
   assign dmaIf.clear = dmaStatusRead; // [R2]
   assign scsiIf.wipe = st.softReset; // [R8]
   assign dmaIf.wipe = st.softReset; // [R8]
   assign scsiIf.evt = st.softReset ? '0 : scsiEvent;

   // The abort bit keeps raising an abort event until software writes it to zero.
   always_comb begin
      dmaIf.evt = st.softReset ? '0 : dmaEvent;
      if (st.abortBit && !st.softReset) begin
         dmaIf.evt[`SIST_DMA_EV_ABORT] = 1'b1; // [R6]
      end
   end

   assign scsiCause = scsiIf.status;
   assign dmaCause = dmaIf.status;

   // ====================
   // Register read views
   always_comb begin
      intStatusRead = `SIST_RST_INT_STATUS;
      intStatusRead[`SIST_BIT_ABORT] = st.abortBit;
      intStatusRead[`SIST_BIT_SOFT_RESET] = st.softReset;
      intStatusRead[`SIST_BIT_SIGNAL] = st.signalFlag;
      intStatusRead[`SIST_BIT_CONNECTED] = st.connected & onScsiBus; // [R12]
      intStatusRead[`SIST_BIT_SCSI_PEND] = scsiPend;
      intStatusRead[`SIST_BIT_DMA_PEND] = dmaPend;
   end

   always_comb begin
      chipTestRead = {REVISION, `SIST_RST_CHIP_TEST_LOW}; // [R15]
      chipTestRead[`SIST_BIT_FLUSH] = st.flushBit;
      chipTestRead[`SIST_BIT_CLEAR_FIFOS] = st.clearBit;
      chipTestRead[`SIST_BIT_FETCH_MODE] = st.fetchModeBit;
      chipTestRead[`SIST_BIT_SNOOP_MODE] = st.snoopModeBit;
   end

   assign commitWrite = st.awPend && st.wPend && !st.bValid;
   assign wIdx = st.awAddr[9:2];
   assign rIdx = s_axi_araddr[9:2];
   assign wLane = st.wStrb0;

   // ====================
   // Next state
   always_comb begin
      next_st = st;

      // Bus handshakes: address and data are taken in either order.
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.awPend = 1'b1;
         next_st.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.wPend = 1'b1;
         next_st.wData = s_axi_wdata[7:0];
         next_st.wStrb0 = s_axi_wstrb[0];
      end
      if (st.bValid && s_axi_bready) begin
         next_st.bValid = 1'b0;
      end
      if (st.rValid && s_axi_rready) begin
         next_st.rValid = 1'b0;
      end

      // Hardware-driven register bits.
      if (!onScsiBus) begin
         next_st.connected = 1'b0; // [R12]
      end
      if (arbitrationWon || selectionResponded) begin
         next_st.connected = 1'b1; // [R12]
      end
      if (signalPollClear) begin
         next_st.signalFlag = 1'b0; // [R10]
      end
      if (clearFifosDone) begin
         next_st.clearBit = 1'b0; // [R17]
      end
      if (parityByteValid) begin
         next_st.parity = st.parity ^ parityByte; // [R21]
      end
      if (idLoad) begin
         next_st.parity = idValue; // [R22]
      end

      // Register writes, applied once both halves have arrived.
      if (commitWrite) begin
         next_st.awPend = 1'b0;
         next_st.wPend = 1'b0;
         next_st.bValid = 1'b1;
         next_st.bResp = `SIST_RESP_OKAY;
         if (wIdx == `SIST_IDX_INT_STATUS) begin
            if (wLane) begin
               next_st.abortBit = st.wData[`SIST_BIT_ABORT]; // [R6] [R7]
               // Only a host write changes this bit; it never clears itself.
               next_st.softReset = st.wData[`SIST_BIT_SOFT_RESET]; // [R9]
               // A poll clear in the same cycle loses to a host write of one.
               next_st.signalFlag = st.wData[`SIST_BIT_SIGNAL] |
                                    (st.signalFlag & ~signalPollClear); // [R10]
            end
         end else if (wIdx == `SIST_IDX_CHIP_TEST) begin
            if (wLane && !st.softReset) begin
               next_st.flushBit = st.wData[`SIST_BIT_FLUSH]; // [R16]
               next_st.clearBit = st.wData[`SIST_BIT_CLEAR_FIFOS] |
                                  (st.clearBit & ~clearFifosDone); // [R17]
               next_st.fetchModeBit = st.wData[`SIST_BIT_FETCH_MODE];
               next_st.snoopModeBit = st.wData[`SIST_BIT_SNOOP_MODE];
            end
         end else if (wIdx == `SIST_IDX_PARITY) begin
            // The written value is ignored; a byte arriving now still counts.
            if (wLane) begin
               next_st.parity = parityByteValid ? parityByte : `SIST_RST_PARITY; // [R21]
            end
         end else begin
            next_st.bResp = `SIST_RESP_SLVERR;
         end
      end

      // Register reads have no side effects in this block.
      if (s_axi_arvalid && s_axi_arready) begin
         next_st.rValid = 1'b1;
         next_st.rResp = `SIST_RESP_OKAY;
         if (rIdx == `SIST_IDX_INT_STATUS) begin
            next_st.rData = intStatusRead;
         end else if (rIdx == `SIST_IDX_CHIP_TEST) begin
            next_st.rData = chipTestRead;
         end else if (rIdx == `SIST_IDX_PARITY) begin
            next_st.rData = st.parity;
         end else begin
            next_st.rData = 8'h00;
            next_st.rResp = `SIST_RESP_SLVERR;
         end
      end

      // Orderly halt: the interrupt waits for the sequencer to stop.
      case (st.halt)
         HALT_RUN: begin
            if (scsiPend || dmaPend) begin
               next_st.halt = HALT_WAIT; // [R3]
            end
         end
         HALT_WAIT: begin
            if (haltAck) begin
               next_st.halt = HALT_DONE; // [R3]
            end
         end
         HALT_DONE: begin
            if (!scsiPend && !dmaPend) begin
               next_st.halt = HALT_RUN;
            end
         end
         default: begin
            next_st.halt = HALT_RUN;
         end
      endcase

      // Pin synchroniser: a change counts once the second and third stages agree.
      next_st.hiZSync = {st.hiZSync[1:0], hiZTestPin};
      if (st.hiZSync[1] == st.hiZSync[2]) begin
         next_st.hiZ = st.hiZSync[2];
      end

      // Soft reset holds the other register bits at default, but a status write still loads the abort and signal bits.
      if (st.softReset) begin
         next_st.abortBit = 1'b0; // [R8]
         next_st.signalFlag = 1'b0; // [R8]
         next_st.connected = 1'b0; // [R8]
         next_st.flushBit = 1'b0; // [R8]
         next_st.clearBit = 1'b0; // [R8]
         next_st.fetchModeBit = 1'b0; // [R8]
         next_st.snoopModeBit = 1'b0; // [R8]
         next_st.parity = `SIST_RST_PARITY; // [R8]
         next_st.halt = HALT_RUN; // [R8]
         if (commitWrite && wIdx == `SIST_IDX_INT_STATUS && wLane) begin
            next_st.abortBit = st.wData[`SIST_BIT_ABORT];
            next_st.signalFlag = st.wData[`SIST_BIT_SIGNAL];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ====================
   // Bus outputs
   // One write and one read at a time; a held response blocks the next request.
   assign s_axi_awready = !st.awPend && !st.bValid;
   assign s_axi_wready = !st.wPend && !st.bValid;
   assign s_axi_bvalid = st.bValid;
   assign s_axi_bresp = st.bResp;
   assign s_axi_arready = !st.rValid;
   assign s_axi_rvalid = st.rValid;
   assign s_axi_rdata = {24'h000000, st.rData};
   assign s_axi_rresp = st.rResp;

   // ====================
   // Halt and interrupt outputs
   assign irq = (st.halt == HALT_DONE) && (scsiPend || dmaPend); // [R3]
   assign haltRequest = (st.halt == HALT_WAIT); // [R3]
   // A fetch in flight is finished unless the bus or the watchdog failed.
   assign haltSkipFetch = dmaIf.status[`SIST_DMA_EV_BUS_FAULT] |
                          dmaIf.status[`SIST_DMA_EV_WATCHDOG]; // [R3]
   assign haltDrainFifo = haltRequest & dmaWriteActive; // [R4]
   assign haltCurrentCycleOnly = haltRequest & ~dmaWriteActive; // [R4]
   assign haltAbortPhaseWait = haltRequest & phaseWaitActive; // [R5]
   assign abortRequest = st.abortBit; // [R6]

   // ====================
   // Soft reset, signal flag and FIFO control outputs
   // Bits kept outside this block stay untouched; only the level is exported.
   assign softResetActive = st.softReset; // [R8]
   assign scsiSignalsRelease = st.softReset; // [R8]
   assign selWaitBranch = st.signalFlag; // [R10]
   assign autoRoleSwitchEn = ~st.signalFlag; // [R11]
   assign flushFifo = st.flushBit; // [R16]
   assign clearFifos = st.clearBit; // [R17]

   // ====================
   // Fetch indicator and snoop pins
   assign fetchIndicator = st.fetchModeBit ? (fetchCycle & fetchOpcodePhase)
                                           : fetchCycle; // [R18]

   always_comb begin
      if (st.snoopModeBit) begin
         snoopPinZero = internalBusReq; // [R19]
         snoopPinOne = snoopCtlBits[1]; // [R19]
         snoopPinZeroOe = ~st.hiZ; // [R19]
         snoopPinOneOe = ~st.hiZ; // [R19]
      end else begin
         snoopPinZero = snoopCtlBits[0]; // [R20]
         snoopPinOne = snoopCtlBits[1]; // [R20]
         snoopPinZeroOe = hostBusOwned & ~st.hiZ; // [R20]
         snoopPinOneOe = hostBusOwned & ~st.hiZ; // [R20]
      end
   end

endmodule

// File: sist_ctrl_monitor.sv
// Concurrent checks on the ports of the interrupt status block.
`timescale 1ns/1ps
module sist_ctrl_monitor (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Bus and status traffic
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [7:0] scsiEvent,
   input wire logic scsiStatusRead,
   input wire logic dmaStatusRead,
   input wire logic [7:0] scsiCause,
   input wire logic [5:0] dmaCause,
   input wire logic irq,
   input wire logic haltRequest,
   // Control outputs
   input wire logic softResetActive,
   input wire logic selWaitBranch,
   input wire logic autoRoleSwitchEn,
   input wire logic clearFifos,
   input wire logic clearFifosDone
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // With both write halves ready no register write can land at this edge.
   wire logic idle = s_axi_awready && s_axi_wready;
   wire logic calm = idle && !softResetActive && !scsiStatusRead && !dmaStatusRead;
   wire logic busy = (scsiCause | dmaCause) != 8'h00;
   property p_freeze; busy && calm |=> $stable({scsiCause, dmaCause}); endproperty
   a_freeze: assert property (p_freeze) else $error("latch moved");
   property p_halt; haltRequest |-> !irq && busy; endproperty
   a_halt: assert property (p_halt) else $error("irq before halt");
   property p_irq; irq && calm |=> irq; endproperty
   a_irq: assert property (p_irq) else $error("irq dropped");
   property p_scsi; scsiEvent != 8'h00 && !busy && calm |=> scsiCause == $past(scsiEvent); endproperty
   a_scsi: assert property (p_scsi) else $error("event lost");
   property p_soft; softResetActive[*2] |-> !irq && !busy; endproperty
   a_soft: assert property (p_soft) else $error("soft reset leak");
   property p_keep; softResetActive && idle |=> softResetActive; endproperty
   a_keep: assert property (p_keep) else $error("soft reset cleared");
   property p_role; selWaitBranch |-> !autoRoleSwitchEn; endproperty
   a_role: assert property (p_role) else $error("role switch on");
   property p_clear; clearFifos && clearFifosDone && idle |=> !clearFifos; endproperty
   a_clear: assert property (p_clear) else $error("clear stuck");
endmodule

// File: sist_seq_model.sv
// Sequencer model that acknowledges halts and FIFO clears.
`timescale 1ns/1ps
module sist_seq_model #(
   parameter int DLY = 3
) (
   input wire logic core_clk,
   input wire logic haltRequest,
   input wire logic clearFifos,
   output logic haltAck = 1'b0,
   output logic clearFifosDone = 1'b0
);
   int n = 0;
   // A late acknowledge keeps the halt in its wait state for a while.
   always @(posedge core_clk) begin
      n <= haltRequest ? n + 1 : 0;
      haltAck <= haltRequest && n == DLY;
      clearFifosDone <= clearFifos;
   end
endmodule

// File: scsi_ioproc_int_status_test_regs_test.sv
// Self-checking bench for the interrupt status, chip test and parity registers.
`timescale 1ns/1ps
module scsi_ioproc_int_status_test_regs_test;
   localparam logic [3:0] REV = 4'hA; // Arbitrary revision code.
   localparam logic [9:0] AIS = 10'h084, ACT = 10'h088, APA = 10'h08C;
   int err_count = 0, check_count = 0;
   logic core_clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, scsiStatusRead = 0, dmaStatusRead = 0;
   logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
   logic [7:0] scsiEvent = 0, parityByte = 0, idValue = 0, scsiCause;
   logic [5:0] dmaEvent = 0, dmaCause;
   logic [1:0] snoopCtlBits = 0, s_axi_bresp, s_axi_rresp;
   logic signalPollClear = 0, arbitrationWon = 0, selectionResponded = 0, onScsiBus = 0;
   logic fetchCycle = 0, fetchOpcodePhase = 0, internalBusReq = 0, hostBusOwned = 0;
   logic hiZTestPin = 0, parityByteValid = 0, idLoad = 0, dmaWriteActive = 0, phaseWaitActive = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, haltAck;
   logic haltRequest, haltSkipFetch, haltDrainFifo, haltCurrentCycleOnly, haltAbortPhaseWait;
   logic abortRequest, softResetActive, scsiSignalsRelease, selWaitBranch, autoRoleSwitchEn;
   logic flushFifo, clearFifos, clearFifosDone, fetchIndicator, snoopPinZero, snoopPinZeroOe;
   logic snoopPinOne, snoopPinOneOe;
   sist_ctrl #(.REVISION(REV)) sist_ctrl_inst (.*);
   sist_seq_model sist_seq_model_inst (.*);
   initial forever #25 core_clk = ~core_clk;
   // The whole sequence needs well under a thousand cycles.
   initial begin
      #100000;
      err_count++;
      tally_and_finish();
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   // Readies are sampled mid-cycle so each release follows the edge that took it.
   task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [1:0] r);
      logic ta, tw, tr, td;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, 24'h0, d};
      do begin
         @(negedge core_clk);
         {ta, tw, tr} = {s_axi_awready, s_axi_wready, s_axi_arready};
         td = w ? s_axi_bvalid : s_axi_rvalid;
         if (td && !w) chk(s_axi_rdata, {24'h0, d});
         if (td) chk(w ? s_axi_bresp : s_axi_rresp, r);
         @(posedge core_clk);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
         if (tr) s_axi_arvalid <= 0;
      end while (!td);
      {s_axi_bready, s_axi_rready} <= 2'h0;
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
      xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic [1:0] r = 2'h0);
      xfer(1'b0, a, e, r);
   endtask
   task automatic wirq(input logic v);
      int n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (irq !== v && n < 40);
      chk(irq, v);
      @(posedge core_clk);
   endtask
   task automatic t_defaults();
      rd(AIS, 8'h00);
      rd(ACT, {REV, 4'h0});
      rd(APA, 8'h00);
      wr(10'h090, 8'hFF, 2'h2);
      rd(10'h090, 8'h00, 2'h2);
   endtask
   task automatic t_chip();
      wr(ACT, 8'h0B);
      {fetchCycle, internalBusReq, snoopCtlBits} <= 4'hE;
      @(negedge core_clk);
      chk({flushFifo, fetchIndicator}, 2'h2);
      chk({snoopPinZeroOe, snoopPinOneOe, snoopPinZero, snoopPinOne}, 4'hF);
      @(posedge core_clk);
      fetchOpcodePhase <= 1;
      wr(ACT, 8'h04);
      repeat (2) @(posedge core_clk);
      rd(ACT, {REV, 4'h0});
      fetchOpcodePhase <= 0;
      @(negedge core_clk);
      chk({fetchIndicator, snoopPinZeroOe, snoopPinOneOe}, 3'h4);
      @(posedge core_clk);
      {hostBusOwned, snoopCtlBits} <= 3'h5;
      @(negedge core_clk);
      chk({snoopPinZeroOe, snoopPinOneOe, snoopPinZero, snoopPinOne}, 4'hE);
      @(posedge core_clk);
      {fetchCycle, hostBusOwned} <= 2'h0;
   endtask
   task automatic t_irq();
      {dmaWriteActive, phaseWaitActive, scsiEvent} <= {2'h3, 8'hDB};
      @(posedge core_clk);
      scsiEvent <= 8'h24;
      @(posedge core_clk);
      scsiEvent <= 0;
      wirq(1);
      rd(AIS, 8'h02);
      chk(scsiCause, 8'hDB);
      scsiStatusRead <= 1;
      @(posedge core_clk);
      scsiStatusRead <= 0;
      @(negedge core_clk);
      chk({irq, scsiCause}, 9'h124);
      @(posedge core_clk);
      scsiStatusRead <= 1;
      @(posedge core_clk);
      scsiStatusRead <= 0;
      wirq(0);
      dmaEvent <= 6'h3F;
      @(posedge core_clk);
      dmaEvent <= 0;
      @(posedge core_clk);
      @(negedge core_clk);
      chk({haltRequest, haltSkipFetch, haltDrainFifo, haltCurrentCycleOnly,
           haltAbortPhaseWait}, 5'h1D);
      @(posedge core_clk);
      wirq(1);
      rd(AIS, 8'h01);
      dmaStatusRead <= 1;
      @(posedge core_clk);
      {dmaStatusRead, dmaWriteActive, phaseWaitActive} <= 3'h0;
      wirq(0);
   endtask
   task automatic t_abort();
      wr(AIS, 8'h80);
      wirq(1);
      rd(AIS, 8'h81);
      chk({abortRequest, dmaCause[1]}, 2'h3);
      wr(AIS, 8'h00);
      chk(abortRequest, 0);
   endtask
   task automatic t_soft();
      wr(AIS, 8'h40);
      rd(AIS, 8'h40);
      wr(ACT, 8'h0F);
      rd(ACT, {REV, 4'h0});
      chk({irq, softResetActive, scsiSignalsRelease}, 3'h3);
      wr(AIS, 8'h00);
      chk(softResetActive, 0);
   endtask
   task automatic t_sig();
      wr(AIS, 8'h20);
      chk({selWaitBranch, autoRoleSwitchEn}, 2'h2);
      {signalPollClear, onScsiBus, arbitrationWon} <= 3'h7;
      @(posedge core_clk);
      {signalPollClear, arbitrationWon} <= 2'h0;
      rd(AIS, 8'h08);
      onScsiBus <= 0;
      rd(AIS, 8'h00);
      {onScsiBus, selectionResponded} <= 2'h3;
      @(posedge core_clk);
      selectionResponded <= 0;
      rd(AIS, 8'h08);
   endtask
   task automatic t_par();
      {parityByte, parityByteValid} <= {8'h5A, 1'b1};
      @(posedge core_clk);
      parityByte <= 8'h0F;
      @(posedge core_clk);
      parityByteValid <= 0;
      rd(APA, 8'h55);
      wr(APA, 8'hC3);
      rd(APA, 8'h00);
      {idValue, idLoad} <= {8'h07, 1'b1};
      @(posedge core_clk);
      idLoad <= 0;
      rd(APA, 8'h07);
   endtask
   task automatic tally_and_finish();
      if (err_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1;
      t_defaults();
      t_chip();
      t_irq();
      t_abort();
      t_soft();
      t_sig();
      t_par();
      tally_and_finish();
   end
endmodule
bind sist_ctrl sist_ctrl_monitor sist_ctrl_monitor_inst (.*);
